/* File: verification/operand_address_gen_test.sv */
/*
  Self-checking bench for operand_address_gen: a reference model in the
  driver queues expected results, a monitor pops and compares them.
  Assumes the design's own assertions and covers sit in its files.
*/
`timescale 1ns/10ps
`include "opgen_regs.svh"

module operand_address_gen_test import opgen_pkg::*;;
  typedef struct {int at; int kind; logic [31:0] v; logic [31:0] w; logic [3:0] be; logic b;} note_t;
  localparam int KR = 0, KW = 1, KA = 2, KL = 3, KP = 4, KQ = 5, KN = 6, KF = 7;
  logic        clk = 0, resetn = 0, valid = 0, cancel = 0, dcache = 0;
  op_t         op = OP_OTHER;
  logic [10:0] imm = '0;
  logic [4:0]  idx = '0;
  logic [31:0] av = '0, dv = '0, ps = '0, pc = '0;
  logic [31:0] EA, WR_DATA, OPERAND_B, PC_TARGET, LINK_DATA;
  logic        MEM_RD, MEM_WR, CACHE_USE, B_IS_IMM, PC_LOAD, LINK_WR, ADDR_REG_FAULT;
  logic [3:0]  BYTE_EN;
  logic [31:0] seed = 32'h0000_0056;
  int          cyc = 0, error_cnt = 0, tests_run = 0;
  note_t       q[$];
  note_t       n;
  bit          hit;
  logic        pv = 0, io = 0, pend = 0;
  logic [10:0] pk = '0;
  logic [31:0] ptgt = '0;

  operand_address_gen i_operand_address_gen (
    .CLK(clk), .RESETN(resetn), .INSTR_VALID(valid), .INSTR_CANCEL(cancel), .OP(op),
    .IMM_FIELD(imm), .ADDR_REG_IDX(idx), .ADDR_REG_VAL(av), .DATA_REG_VAL(dv),
    .PARTIAL_SRC_VAL(ps), .PC(pc), .DCACHE_EN(dcache), .EA(EA), .MEM_RD(MEM_RD),
    .MEM_WR(MEM_WR), .BYTE_EN(BYTE_EN), .WR_DATA(WR_DATA), .CACHE_USE(CACHE_USE),
    .OPERAND_B(OPERAND_B), .B_IS_IMM(B_IS_IMM), .PC_LOAD(PC_LOAD), .PC_TARGET(PC_TARGET),
    .LINK_WR(LINK_WR), .LINK_DATA(LINK_DATA), .ADDR_REG_FAULT(ADDR_REG_FAULT));

  always #2 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  function automatic void put(int d, int k, logic [31:0] v, logic [31:0] w, logic [3:0] be,
                              logic b);
    q.push_back('{cyc + d, k, v, w, be, b});
  endfunction

  task automatic go(input op_t o, input logic [10:0] i, input logic [4:0] x,
                    input logic [31:0] a, input logic [31:0] d, input logic cn);
    logic [31:0] k4, base, wa, s;
    logic [9:0]  off;
    logic        slot, ok, cu;
    s = rnd();
    valid = 1; cancel = cn; op = o; imm = i; idx = x; av = a; dv = d; ps = s;
    pc = {rnd() & 32'h0FFF_FFFE};
    k4 = pv ? {{19{pk[10]}}, pk, 2'b00} : `ZERO32;
    wa = a & `WORD_MASK;
    base = wa + k4;
    cu = dcache & ~(pv & io);
    off = {i[8:0], 1'b0};
    slot = pend;
    pend = 0;
    if (cn) begin
      put(1, KQ, 0, 0, 0, 0);
      if (o inside {OP_REL_JUMP, OP_REL_JUMP_LINK, OP_REG_JUMP, OP_REG_JUMP_LINK})
        put(2, KN, 0, 0, 0, 0);
      pv = 0;
    end else begin
      ok = (x == `SP_IDX);
      case (o)
        OP_ALU_IMM: put(1, KA, pv ? {16'h0000, pk, i[4:0]} : {27'h0, i[4:0]}, 0, 0, 1);
        OP_LOGIC: put(1, KA, pv ? {16'h0000, pk, i[4:0]} : d, 0, 0, pv);
        OP_WIDE_IMM: put(1, KA, {21'h0, i}, 0, 0, 1);
        OP_IND_READ: put(1, KR, base, 0, `ALL_LANES, cu);
        OP_IND_WRITE: put(1, KW, base, d, `ALL_LANES, 0);
        OP_PTR_READ, OP_PTR_WRITE, OP_FRAME_READ, OP_FRAME_WRITE: begin
          if (o inside {OP_PTR_READ, OP_PTR_WRITE}) begin
            ok = (x inside {[5'h10:5'h13]});
            base = base + {25'h0, i[4:0], 2'b00};
          end else begin
            base = base + {22'h0, i[7:0], 2'b00};
            cu = dcache;
          end
          if (!ok) put(1, KF, 0, 0, 0, 0);
          else put(1, (o == OP_PTR_READ || o == OP_FRAME_READ) ? KR : KW, base, d, `ALL_LANES, cu);
        end
        OP_BYTE_FIXED: put(1, KW, base, s, `LANE_ONE << i[1:0], 0);
        OP_HALF_FIXED: put(1, KW, base, s, i[0] ? `HALF_HI : `HALF_LO, 0);
        OP_BYTE_DYN: put(1, KW, base, s, `LANE_ONE << a[1:0], 0);
        OP_HALF_DYN: put(1, KW, base, s, a[1] ? `HALF_HI : `HALF_LO, 0);
        OP_FRAME_BYTE: if (ok) put(1, KW, wa + {22'h0, i[9:2], 2'b00}, s, `LANE_ONE << i[1:0], 0);
                       else put(1, KF, 0, 0, 0, 0);
        OP_FRAME_HALF: if (ok) put(1, KW, wa + {22'h0, off[9:2], 2'b00}, s,
                                   off[1] ? `HALF_HI : `HALF_LO, 0);
                       else put(1, KF, 0, 0, 0, 0);
        OP_REL_JUMP, OP_REL_JUMP_LINK, OP_REG_JUMP, OP_REG_JUMP_LINK: begin
          put(1, KL, pc + `RET_OFS, 0, 0, o inside {OP_REL_JUMP_LINK, OP_REG_JUMP_LINK});
          pend = 1;
          ptgt = (o inside {OP_REG_JUMP, OP_REG_JUMP_LINK}) ? {d[30:0], 1'b0}
                 : pc + {{20{i[10]}}, i, 1'b0} + `BR_BIAS;
        end
        default: ;
      endcase
      pv = o inside {OP_PREFIX, OP_IO_PREFIX};
      io = (o == OP_IO_PREFIX);
      pk = i;
    end
    if (slot) put(1, KP, ptgt, 0, 0, 0);
    @(negedge clk);
  endtask

  task automatic idle(input int c);
    valid = 0;
    repeat (c) @(negedge clk);
  endtask

  // monitor: every note whose cycle has come is taken, oldest first, and compared
  always @(negedge clk) begin
    hit = 0;
    while (q.size() > 0 && q[0].at <= cyc) begin
      n = q.pop_front();
      hit = 1;
      case (n.kind)
        KR, KW: begin
          chk(EA, n.v, "address");
          chk(32'({MEM_RD, MEM_WR, ADDR_REG_FAULT}), (n.kind == KR) ? 32'd4 : 32'd2, "strobes");
          chk(32'(BYTE_EN), 32'(n.be), "lanes");
          if (n.kind == KW) chk(WR_DATA, n.w, "write data");
          else chk(32'(CACHE_USE), 32'(n.b), "cache use");
        end
        KA: begin
          chk(OPERAND_B, n.v, "operand b");
          chk(32'(B_IS_IMM), 32'(n.b), "operand kind");
        end
        KL: chk(LINK_WR ? LINK_DATA : `ZERO32, n.b ? n.v : `ZERO32, "link");
        KP: begin
          chk(32'(PC_LOAD), 32'd1, "target load");
          chk(PC_TARGET, n.v, "target");
        end
        KN: chk(32'(PC_LOAD), 32'd0, "cancelled transfer");
        KQ: chk(32'({MEM_RD, MEM_WR, LINK_WR, ADDR_REG_FAULT}), 32'd0, "cancelled");
        default: chk(32'({MEM_RD, MEM_WR, ADDR_REG_FAULT}), 32'd1, "fault");
      endcase
    end
    if (!hit && resetn) chk(32'({MEM_RD, MEM_WR, PC_LOAD, LINK_WR}), 32'd0, "stray pulse");
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // the run needs well under a thousand cycles
  initial begin
    repeat (3000) @(posedge clk);
    error_cnt++;
    $display("BAD %0t watchdog expired", $time);
    conclude();
  end

  initial begin
    logic [31:0] r, i;
    op_t ops[18] = '{OP_OTHER, OP_PREFIX, OP_IO_PREFIX, OP_ALU_IMM, OP_LOGIC, OP_WIDE_IMM,
                     OP_IND_READ, OP_IND_WRITE, OP_PTR_READ, OP_PTR_WRITE, OP_FRAME_READ,
                     OP_FRAME_WRITE, OP_BYTE_FIXED, OP_HALF_FIXED, OP_BYTE_DYN, OP_HALF_DYN,
                     OP_FRAME_BYTE, OP_FRAME_HALF};
    repeat (5) @(negedge clk);
    chk(EA | {27'h0, MEM_RD, MEM_WR, PC_LOAD, LINK_WR, ADDR_REG_FAULT}, `ZERO32, "reset");
    resetn = 1;
    go(OP_ALU_IMM, 11'h01F, 5'h01, `ZERO32, `ZERO32, 0);
    go(OP_PREFIX, 11'h091, 5'h01, `ZERO32, `ZERO32, 0);
    go(OP_ALU_IMM, 11'h014, 5'h01, `ZERO32, `ZERO32, 0);
    go(OP_ALU_IMM, 11'h7F5, 5'h01, `ZERO32, `ZERO32, 0);
    go(OP_PREFIX, 11'h7FF, 5'h01, `ZERO32, `ZERO32, 0);
    idle(2);
    go(OP_LOGIC, 11'h01F, 5'h01, `ZERO32, 32'h1357_9BDF, 0);
    go(OP_LOGIC, 11'h01F, 5'h01, `ZERO32, 32'h2468_ACE0, 0);
    go(OP_PREFIX, 11'h123, 5'h01, `ZERO32, `ZERO32, 1);
    go(OP_ALU_IMM, 11'h003, 5'h01, `ZERO32, `ZERO32, 0);
    $display("test immediates done");
    go(OP_PREFIX, 11'h400, 5'h01, `ZERO32, `ZERO32, 0);
    go(OP_IND_READ, 11'h000, 5'h03, 32'h0000_3003, `ZERO32, 0);
    go(OP_PREFIX, 11'h3FF, 5'h01, `ZERO32, `ZERO32, 0);
    go(OP_IND_WRITE, 11'h000, 5'h1F, 32'h0000_1002, 32'hA5A5_0F0F, 0);
    dcache = 1;
    go(OP_IO_PREFIX, 11'h001, 5'h01, `ZERO32, `ZERO32, 0);
    go(OP_IND_READ, 11'h000, 5'h09, 32'h0000_0100, `ZERO32, 0);
    go(OP_IO_PREFIX, 11'h000, 5'h01, `ZERO32, `ZERO32, 0);
    go(OP_PTR_READ, 11'h000, 5'h12, 32'h0000_0200, `ZERO32, 0);
    go(OP_FRAME_READ, 11'h0FF, `SP_IDX, 32'h0000_8001, `ZERO32, 0);
    $display("test word access done");
    for (int l = 0; l < 4; l++) begin
      go(OP_BYTE_DYN, 11'h000, 5'h07, 32'h0000_1200 + l, 32'hDEAD_BEEF, 0);
      go(OP_HALF_DYN, 11'h000, 5'h07, 32'h0000_1200 + l, 32'hDEAD_BEEF, 0);
      go(OP_BYTE_FIXED, 11'(l), 5'h02, 32'h0000_2003, 32'hDEAD_BEEF, 0);
      go(OP_HALF_FIXED, 11'(l), 5'h02, 32'h0000_2003, 32'hDEAD_BEEF, 0);
      go(OP_PTR_WRITE, 11'h01F, 5'h10 + 5'(l), rnd(), rnd(), 0);
    end
    go(OP_PREFIX, 11'h7FE, 5'h01, `ZERO32, `ZERO32, 0);
    go(OP_BYTE_FIXED, 11'h001, 5'h04, 32'h0000_4000, `ZERO32, 0);
    go(OP_PTR_READ, 11'h000, 5'h0F, 32'h0000_0040, `ZERO32, 0);
    go(OP_PTR_READ, 11'h000, 5'h14, 32'h0000_0040, `ZERO32, 0);
    go(OP_FRAME_WRITE, 11'h0FF, `SP_IDX, 32'h0000_5002, rnd(), 0);
    go(OP_FRAME_WRITE, 11'h000, 5'h10, 32'h0000_5000, rnd(), 0);
    go(OP_FRAME_BYTE, 11'h3FF, `SP_IDX, 32'h0000_6001, `ZERO32, 0);
    go(OP_FRAME_HALF, 11'h1FF, `SP_IDX, 32'h0000_6001, `ZERO32, 0);
    $display("test partial writes done");
    go(OP_REL_JUMP, 11'h3FF, 5'h01, `ZERO32, `ZERO32, 0);
    idle(1);
    go(OP_ALU_IMM, 11'h007, 5'h01, `ZERO32, `ZERO32, 0);
    go(OP_REL_JUMP_LINK, 11'h400, 5'h01, `ZERO32, `ZERO32, 0);
    go(OP_IND_READ, 11'h000, 5'h05, 32'h0000_0700, `ZERO32, 0);
    go(OP_REG_JUMP_LINK, 11'h000, 5'h01, `ZERO32, rnd(), 0);
    idle(1);
    go(OP_OTHER, 11'h000, 5'h01, `ZERO32, `ZERO32, 1);
    go(OP_REG_JUMP, 11'h000, 5'h01, `ZERO32, rnd(), 0);
    go(OP_ALU_IMM, 11'h001, 5'h01, `ZERO32, `ZERO32, 0);
    go(OP_REL_JUMP, 11'h010, 5'h01, `ZERO32, `ZERO32, 1);
    go(OP_ALU_IMM, 11'h002, 5'h01, `ZERO32, `ZERO32, 0);
    $display("test transfers done");
    repeat (400) begin
      r = rnd();
      i = rnd();
      op = ops[r % 18];
      if (pv && io && op == OP_FRAME_READ) op = OP_IND_READ;
      dcache = r[5];
      go(op, i[10:0], r[8] ? r[13:9] : (r[9] ? `SP_IDX : 5'h10 + 5'(r[11:10])), rnd(), rnd(),
         r[31:29] == 3'b000);
    end
    $display("test random done");
    idle(3);
    conclude();
  end
endmodule

/* File: verilog/operand_address_gen.sv */
/*
  Operand and effective-address formation for a 32-bit soft CPU:
  prefix register, immediates, load/store addresses, lanes, branch and
  jump targets with one delay slot, link value.
  Assumes a decoder supplies the op class, immediate field, register
  values and index of the address register; skip logic drives CANCEL.
*/
// Summary of operation
// - frame word reads always go through the data cache when enabled
// - unprefixed short immediate is 5 bits unsigned, value 0 to 31
// - prefix loads 11-bit register, placed above 5-bit immediate making 16 bits
// - prefix value only reaches the instruction right after the prefix
// - other-width immediates pass unchanged, prefix register ignored
// - logic ops use two registers unprefixed, register plus 16-bit immediate prefixed
// - indirect address is signed prefix times 4 plus word-aligned register
// - prefix displacement spans -4096 to 4092 bytes from aligned base
// - indirect word read and write accept any address and data register
// - no partial-word reads exist; reads are always full words
// - dynamic partial writes pick lane from address register low bits
// - fixed partial writes pick lane from 2-bit or 1-bit immediate
// - non-frame partial writes add signed prefix word offset to aligned register
// - partial writes take data only from the partial source register
// - pointer word accesses accept only the four pointer registers as address
// - frame word accesses accept only the stack pointer as address
// - indexed forms add word index; reach 124 or 1020 bytes unprefixed
// - frame partial writes reach 0 to 1023 bytes or 0 to 511 halves
// - relative target comes from branch address and 11-bit offset field
// - relative jump with link also writes return address to link register
// - jumps are unconditional; only a preceding skip cancels them
// - one delay slot instruction runs before the relative branch target
// - relative reach is 2048 bytes forward and 2046 bytes backward
// - register jump loads register shifted left one; link form saves return
// - io-prefixed indirect or pointer reads bypass the data cache
// - one delay slot instruction runs before the register jump target
`timescale 1ns/10ps
`include "opgen_regs.svh"

module operand_address_gen import opgen_pkg::*; (
  input  wire logic        CLK,             // cpu clock, 250 MHz
  input  wire logic        RESETN,          // async reset, active low
  input  wire logic        INSTR_VALID,     // instruction issued this cycle
  input  wire logic        INSTR_CANCEL,    // issued but cancelled by a skip
  input  wire op_t         OP,              // decoded operation class
  input  wire logic [10:0] IMM_FIELD,       // raw immediate field
  input  wire logic [4:0]  ADDR_REG_IDX,    // index of the address register
  input  wire logic [31:0] ADDR_REG_VAL,    // address register contents
  input  wire logic [31:0] DATA_REG_VAL,    // second / data register contents
  input  wire logic [31:0] PARTIAL_SRC_VAL, // partial_source_reg contents
  input  wire logic [31:0] PC,              // address of this instruction
  input  wire logic        DCACHE_EN,       // data cache enabled
  output logic      [31:0] EA,              // effective address
  output logic             MEM_RD,          // word read request
  output logic             MEM_WR,          // write request
  output logic      [3:0]  BYTE_EN,         // lanes read or written
  output logic      [31:0] WR_DATA,         // write data
  output logic             CACHE_USE,       // read served via the data cache
  output logic      [31:0] OPERAND_B,       // second alu operand
  output logic             B_IS_IMM,        // operand b is an immediate
  output logic             PC_LOAD,         // load PC_TARGET now
  output logic      [31:0] PC_TARGET,       // transfer target
  output logic             LINK_WR,         // write link_reg
  output logic      [31:0] LINK_DATA,       // return address
  output logic             ADDR_REG_FAULT   // illegal address register
);

  logic        exec;
  logic [10:0] k;
  logic        pfx_live;
  logic        io_live;
  logic        pend;
  logic [31:0] pend_target;
  logic [31:0] k_off;
  logic [31:0] base;
  logic [31:0] next_ea;
  logic        next_rd;
  logic        next_wr;
  logic [3:0]  next_be;
  logic [31:0] next_wdata;
  logic        next_cache;
  logic [31:0] next_opb;
  logic        next_b_imm;
  logic        next_fault;
  logic        is_xfer;
  logic [31:0] xfer_target;
  logic        next_link_wr;
  logic [31:0] br_off;
  logic [1:0]  lane;

  assign exec = INSTR_VALID & ~INSTR_CANCEL;

  // a cancelled prefix leaves no value behind; skip logic cancels its partner
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      k        <= 11'h000;
      pfx_live <= 1'b0;
      io_live  <= 1'b0;
    end else if (INSTR_VALID) begin
      if (exec && (OP == OP_PREFIX || OP == OP_IO_PREFIX)) begin
        k        <= IMM_FIELD;
        pfx_live <= 1'b1;
        io_live  <= (OP == OP_IO_PREFIX);
      end else begin
        pfx_live <= 1'b0;
        io_live  <= 1'b0;
      end
    end
  end

  always_comb begin
    // signed word offset, zero unless a prefix came just before
    k_off = pfx_live ? {{19{k[10]}}, k, 2'b00} : `ZERO32;
    base  = ADDR_REG_VAL & `WORD_MASK;
    lane  = ADDR_REG_VAL[1:0];
    br_off = {{21{IMM_FIELD[10]}}, IMM_FIELD};
  end

  always_comb begin
    next_ea    = `ZERO32;
    next_rd    = 1'b0;
    next_wr    = 1'b0;
    next_be    = `NO_LANES;
    next_wdata = `ZERO32;
    next_cache = 1'b0;
    next_opb   = `ZERO32;
    next_b_imm = 1'b0;
    next_fault = 1'b0;
    case (OP)
      OP_ALU_IMM: begin
        next_b_imm = 1'b1;
        next_opb   = {16'h0000, (pfx_live ? k : 11'h000), IMM_FIELD[4:0]};
      end
      OP_LOGIC: begin
        next_b_imm = pfx_live;
        next_opb   = pfx_live ? {16'h0000, k, IMM_FIELD[4:0]} : DATA_REG_VAL;
      end
      OP_WIDE_IMM: begin
        next_b_imm = 1'b1;
        next_opb   = {21'h00_0000, IMM_FIELD};
      end
      OP_IND_READ, OP_IND_WRITE: begin
        next_ea    = base + k_off;
        next_rd    = (OP == OP_IND_READ);
        next_wr    = (OP == OP_IND_WRITE);
        next_be    = `ALL_LANES;
        next_wdata = DATA_REG_VAL;
        next_cache = next_rd & DCACHE_EN & ~io_live;
      end
      OP_PTR_READ, OP_PTR_WRITE: begin
        next_ea    = base + k_off + {25'h000_0000, IMM_FIELD[4:0], 2'b00};
        next_rd    = (OP == OP_PTR_READ);
        next_wr    = (OP == OP_PTR_WRITE);
        next_be    = `ALL_LANES;
        next_wdata = DATA_REG_VAL;
        next_cache = next_rd & DCACHE_EN & ~io_live;
        next_fault = ((ADDR_REG_IDX & `PTR_GRP_MASK) != `PTR_BASE_IDX);
      end
      OP_FRAME_READ, OP_FRAME_WRITE: begin
        next_ea    = base + k_off + {22'h00_0000, IMM_FIELD[7:0], 2'b00};
        next_rd    = (OP == OP_FRAME_READ);
        next_wr    = (OP == OP_FRAME_WRITE);
        next_be    = `ALL_LANES;
        next_wdata = DATA_REG_VAL;
        // no bypass for this read even after an io prefix
        next_cache = next_rd & DCACHE_EN;
        next_fault = (ADDR_REG_IDX != `SP_IDX);
      end
      OP_BYTE_FIXED, OP_HALF_FIXED, OP_BYTE_DYN, OP_HALF_DYN: begin
        next_ea    = base + k_off;
        next_wr    = 1'b1;
        next_wdata = PARTIAL_SRC_VAL;
        case (OP)
          OP_BYTE_FIXED: next_be = `LANE_ONE << IMM_FIELD[1:0];
          OP_HALF_FIXED: next_be = IMM_FIELD[0] ? `HALF_HI : `HALF_LO;
          OP_BYTE_DYN:   next_be = `LANE_ONE << lane;
          default:       next_be = lane[1] ? `HALF_HI : `HALF_LO;
        endcase
      end
      OP_FRAME_BYTE: begin
        next_ea    = base + {22'h00_0000, IMM_FIELD[9:2], 2'b00};
        next_wr    = 1'b1;
        next_be    = `LANE_ONE << IMM_FIELD[1:0];
        next_wdata = PARTIAL_SRC_VAL;
        next_fault = (ADDR_REG_IDX != `SP_IDX);
      end
      OP_FRAME_HALF: begin
        next_ea    = base + {22'h00_0000, IMM_FIELD[8:1], 2'b00};
        next_wr    = 1'b1;
        next_be    = IMM_FIELD[0] ? `HALF_HI : `HALF_LO;
        next_wdata = PARTIAL_SRC_VAL;
        next_fault = (ADDR_REG_IDX != `SP_IDX);
      end
      default: begin
        next_ea = `ZERO32;
      end
    endcase
  end

  always_comb begin
    is_xfer      = 1'b0;
    xfer_target  = `ZERO32;
    next_link_wr = 1'b0;
    case (OP)
      OP_REL_JUMP, OP_REL_JUMP_LINK: begin
        is_xfer      = 1'b1;
        // offset field -1024..1023 maps to -2046..+2048 bytes
        xfer_target  = PC + {br_off[30:0], 1'b0} + `BR_BIAS;
        next_link_wr = (OP == OP_REL_JUMP_LINK);
      end
      OP_REG_JUMP, OP_REG_JUMP_LINK: begin
        is_xfer      = 1'b1;
        xfer_target  = {DATA_REG_VAL[30:0], 1'b0};
        next_link_wr = (OP == OP_REG_JUMP_LINK);
      end
      default: begin
        is_xfer = 1'b0;
      end
    endcase
  end

  // operand and memory outputs; a cancelled instruction raises no request, cache use, lane or fault
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      EA             <= `ZERO32;
      MEM_RD         <= 1'b0;
      MEM_WR         <= 1'b0;
      BYTE_EN        <= `NO_LANES;
      WR_DATA        <= `ZERO32;
      CACHE_USE      <= 1'b0;
      OPERAND_B      <= `ZERO32;
      B_IS_IMM       <= 1'b0;
      ADDR_REG_FAULT <= 1'b0;
    end else begin
      EA             <= next_ea;
      MEM_RD         <= exec & next_rd & ~next_fault;
      MEM_WR         <= exec & next_wr & ~next_fault;
      BYTE_EN        <= exec ? next_be : `NO_LANES;
      WR_DATA        <= next_wdata;
      CACHE_USE      <= exec & next_cache & ~next_fault;
      OPERAND_B      <= next_opb;
      B_IS_IMM       <= next_b_imm;
      ADDR_REG_FAULT <= exec & next_fault;
    end
  end

  // target is held until the delay-slot instruction issues, then loaded
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      pend        <= 1'b0;
      pend_target <= `ZERO32;
      PC_LOAD     <= 1'b0;
      PC_TARGET   <= `ZERO32;
    end else begin
      PC_LOAD <= 1'b0;
      if (INSTR_VALID && pend) begin
        PC_LOAD   <= 1'b1;
        PC_TARGET <= pend_target;
        pend      <= 1'b0;
      end
      if (exec && is_xfer) begin
        pend        <= 1'b1;
        pend_target <= xfer_target;
      end
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      LINK_WR   <= 1'b0;
      LINK_DATA <= `ZERO32;
    end else begin
      LINK_WR   <= exec & next_link_wr;
      LINK_DATA <= PC + `RET_OFS;
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN);

  AST_FRAME_CACHED: assert property (
    exec && OP == OP_FRAME_READ && DCACHE_EN && ADDR_REG_IDX == `SP_IDX |=> CACHE_USE)
    else $error("frame read not served by cache");
  AST_IO_BYPASS: assert property (
    exec && io_live && !next_fault && (OP == OP_IND_READ || OP == OP_PTR_READ)
    |=> MEM_RD && !CACHE_USE)
    else $error("io-prefixed read used cache");
  AST_SHORT_IMM: assert property (
    exec && OP == OP_ALU_IMM && !pfx_live |=> OPERAND_B == {27'h000_0000, $past(IMM_FIELD[4:0])})
    else $error("short immediate wrong");
  AST_LONG_IMM: assert property (
    exec && OP == OP_PREFIX ##1 exec && OP == OP_ALU_IMM
    |=> OPERAND_B == {16'h0000, $past(IMM_FIELD, 2), $past(IMM_FIELD[4:0])})
    else $error("prefixed immediate wrong");
  AST_PFX_ONCE: assert property (
    INSTR_VALID && OP != OP_PREFIX && OP != OP_IO_PREFIX |=> !pfx_live)
    else $error("prefix value outlived next instruction");
  AST_WIDE_IMM: assert property (
    exec && OP == OP_WIDE_IMM |=> OPERAND_B == {21'h00_0000, $past(IMM_FIELD)})
    else $error("wide immediate modified");
  AST_LOGIC_REG: assert property (
    exec && OP == OP_LOGIC && !pfx_live |=> !B_IS_IMM && OPERAND_B == $past(DATA_REG_VAL))
    else $error("unprefixed logic op not register form");
  AST_IND_EA: assert property (
    exec && OP == OP_IND_READ && !pfx_live |=> EA == ($past(ADDR_REG_VAL) & `WORD_MASK))
    else $error("indirect address not aligned base");
  AST_PARTIAL_SRC: assert property (
    exec && (OP == OP_BYTE_DYN || OP == OP_FRAME_HALF) |=> WR_DATA == $past(PARTIAL_SRC_VAL))
    else $error("partial write data not from partial source");
  AST_PTR_FAULT: assert property (
    exec && OP == OP_PTR_WRITE && ADDR_REG_IDX[4:2] != 3'h4 |=> ADDR_REG_FAULT && !MEM_WR)
    else $error("bad pointer register accepted");
  AST_DELAY_SLOT: assert property (
    exec && OP == OP_REL_JUMP ##1 !INSTR_VALID |=> !PC_LOAD)
    else $error("branch taken before delay slot");
  AST_BR_TARGET: assert property (
    exec && OP == OP_REL_JUMP && !pend ##1 INSTR_VALID
    |=> PC_LOAD && PC_TARGET == $past(PC, 2) + {$past(br_off[30:0], 2), 1'b0} + `BR_BIAS)
    else $error("relative target wrong");
  AST_LINK: assert property (
    exec && OP == OP_REL_JUMP_LINK |=> LINK_WR && LINK_DATA == $past(PC) + `RET_OFS)
    else $error("link not written");
  AST_FRAME_FAULT: assert property (
    exec && OP == OP_FRAME_WRITE && ADDR_REG_IDX != `SP_IDX |=> ADDR_REG_FAULT && !MEM_WR)
    else $error("frame write accepted a non stack register");
  AST_PARTIAL_EA: assert property (
    exec && OP == OP_BYTE_FIXED && pfx_live
    |=> EA == ($past(ADDR_REG_VAL) & `WORD_MASK) + (32'($signed($past(k))) << 2))
    else $error("partial write ignored the prefix offset");
  AST_REG_JUMP: assert property (
    exec && OP == OP_REG_JUMP && !pend ##1 INSTR_VALID
    |=> PC_LOAD && PC_TARGET == {$past(DATA_REG_VAL[30:0], 2), 1'b0})
    else $error("register jump target wrong");
  AST_JUMP_SLOT: assert property (
    exec && OP == OP_REG_JUMP_LINK ##1 !INSTR_VALID |=> !PC_LOAD)
    else $error("jump taken before delay slot");
  AST_WORD_READ: assert property (
    MEM_RD |-> BYTE_EN == `ALL_LANES)
    else $error("partial read issued");
  AST_CANCEL_QUIET: assert property (
    INSTR_VALID && INSTR_CANCEL |=> !MEM_RD && !MEM_WR && !LINK_WR)
    else $error("cancelled instruction had an effect");

  COV_PFX_AND: cover property (exec && OP == OP_PREFIX ##1 exec && OP == OP_LOGIC);
  COV_BRANCH: cover property (exec && OP == OP_REL_JUMP ##1 INSTR_VALID ##1 PC_LOAD);
  COV_BYTE_DYN: cover property (exec && OP == OP_BYTE_DYN ##1 MEM_WR);
  COV_IO_READ: cover property (exec && OP == OP_IO_PREFIX ##1 exec && OP == OP_IND_READ);
  COV_FAULT: cover property (ADDR_REG_FAULT);

endmodule

/* File: verilog/opgen_pkg.sv */
/*
  Types for the operand and effective-address block: the decoded
  operation class supplied by the instruction decoder.
  Assumes the decoder maps every opcode onto one of these classes.
*/
package opgen_pkg;

  typedef enum logic [4:0] {
    OP_OTHER         = 5'h00,
    OP_PREFIX        = 5'h01,
    OP_IO_PREFIX     = 5'h02,
    OP_ALU_IMM       = 5'h03,
    OP_LOGIC         = 5'h04,
    OP_WIDE_IMM      = 5'h05,
    OP_IND_READ      = 5'h06,
    OP_IND_WRITE     = 5'h07,
    OP_PTR_READ      = 5'h08,
    OP_PTR_WRITE     = 5'h09,
    OP_FRAME_READ    = 5'h0A,
    OP_FRAME_WRITE   = 5'h0B,
    OP_BYTE_FIXED    = 5'h0C,
    OP_HALF_FIXED    = 5'h0D,
    OP_BYTE_DYN      = 5'h0E,
    OP_HALF_DYN      = 5'h0F,
    OP_FRAME_BYTE    = 5'h10,
    OP_FRAME_HALF    = 5'h11,
    OP_REL_JUMP      = 5'h12,
    OP_REL_JUMP_LINK = 5'h13,
    OP_REG_JUMP      = 5'h14,
    OP_REG_JUMP_LINK = 5'h15
  } op_t;

endpackage

/* File: verilog/opgen_regs.svh */
/*
  Constants for operand and effective-address formation: field widths,
  register indices, masks and offsets used by the decoder datapath.
  Assumes 32-bit data, 16-bit instructions and byte addressing.
*/
`ifndef OPGEN_REGS_SVH
`define OPGEN_REGS_SVH

`define PFX_W        11
`define IMM5_W       5
`define WORD_MASK    32'hFFFF_FFFC
`define ZERO32       32'h0000_0000
`define BR_BIAS      32'h0000_0002
`define RET_OFS      32'h0000_0004
`define SP_IDX       5'h0E
`define PTR_BASE_IDX 5'h10
`define PTR_GRP_MASK 5'h1C
`define LANE_ONE     4'h1
`define HALF_LO      4'h3
`define HALF_HI      4'hC
`define ALL_LANES    4'hF
`define NO_LANES     4'h0

`endif
